// *** include/fwsr_pkg.sv ***
/*
  package for the flash write-status host poller: bus map, status bit
  positions, command codes and timing constants.
  assumes a 16-bit flash data bus and a 40 MHz system clock.
*/
package fwsr_pkg;
  // system clock
  localparam int CLK_HZ = 40000000;
  // flash strobe timing, ns, rounded up to cycles
  localparam int T_STROBE_NS = 70;
  localparam int STROBE_CYC = (T_STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int T_GAP_NS = 30;
  localparam int GAP_CYC = (T_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
  localparam logic [7:0] GAP_CNT = 8'(GAP_CYC);
  // status bit positions on the flash data bus
  localparam int POLL_BIT = 7;
  localparam int PTOG_BIT = 6;
  localparam int TLIM_BIT = 5;
  localparam int EWIN_BIT = 3;
  localparam int STOG_BIT = 2;
  localparam int BABT_BIT = 1;
  // reset commands written to the flash
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [23:0] ADDR_UNLOCK1 = 24'h000555;
  localparam logic [23:0] ADDR_UNLOCK2 = 24'h0002aa;
  // wishbone register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_DATA = 4'hc;
  // control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_ABRST = 2;
  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_EWIN = 4;
  localparam int ST_SECT = 5;
  localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;
  // polling method
  typedef enum logic {FWSR_TOGGLE, FWSR_DATA} fwsr_mode_t;
  // one flash bus request
  typedef struct packed {
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fwsr_req_t;
  // flash pin bundle
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [23:0] addr;
    logic [15:0] dq;
    logic dq_oe;
  } fwsr_pins_t;
endpackage : fwsr_pkg

// *** core/fwsr_cycle.sv ***
/*
  one asynchronous flash bus cycle (read or write) timed in clock cycles.
  assumes data in is synchronous to the system clock.
*/
`timescale 1ns/1ps
module fwsr_cycle
  import fwsr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // request side
  input wire logic start_in,
  input wire fwsr_req_t req_in,
  output logic done_out,
  output logic [15:0] rdata_out,
  // flash pins
  output fwsr_pins_t pins_out,
  input wire logic [15:0] dq_in
);
  typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_GAP} fwsr_cy_t;
  fwsr_cy_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d; // phase counter
  fwsr_req_t req_q, req_d; // held request
  logic done_q, done_d;
  logic [15:0] rd_q, rd_d;

  ////////////////////////////////////////////////////////////////////
  // next state: strobes fall, hold, rise, then a gap so every read is a
  // distinct cycle and the toggle bit can advance (R12)
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    req_d = req_q;
    done_d = 1'b0;
    rd_d = rd_q;
    unique case (st_q)
      CY_IDLE: begin
        if (start_in) begin
          req_d = req_in;
          cnt_d = STROBE_CNT;
          st_d = CY_ACT;
        end
      end
      CY_ACT: begin
        if (cnt_q <= 8'h01) begin
          // sample data at the end of the strobe, just before release
          if (!req_q.wr) rd_d = dq_in;
          cnt_d = GAP_CNT;
          st_d = CY_GAP;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      CY_GAP: begin
        if (cnt_q <= 8'h01) begin
          done_d = 1'b1;
          st_d = CY_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
    endcase
  end

  // registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= CY_IDLE;
      cnt_q <= 8'h00;
      req_q <= '0;
      done_q <= 1'b0;
      rd_q <= 16'h0000;
    end else if (ce_in) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      done_q <= done_d;
      rd_q <= rd_d;
    end
  end

  // pins come from flops; chip enable released in the gap too
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 24'h000000,
                    dq: 16'h0000, dq_oe: 1'b0};
    end else if (ce_in) begin
      pins_out.ce_n <= (st_d != CY_ACT);
      pins_out.oe_n <= !(st_d == CY_ACT && !req_d.wr);
      pins_out.we_n <= !(st_d == CY_ACT && req_d.wr);
      pins_out.addr <= req_d.addr;
      pins_out.dq <= req_d.wdata;
      pins_out.dq_oe <= (st_d == CY_ACT) && req_d.wr;
    end
  end

  assign done_out = done_q;
  assign rdata_out = rd_q;
endmodule : fwsr_cycle

// *** core/fwsr_wb_regs.sv ***
/*
  classic wishbone slave holding the poller's control and status words.
  assumes a single-cycle classic master; ack one cycle after stb.
*/
`timescale 1ns/1ps
module fwsr_wb_regs
  import fwsr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // wishbone
  input wire logic cyc_in,
  input wire logic stb_in,
  input wire logic we_in,
  input wire logic [3:0] adr_in,
  input wire logic [3:0] sel_in,
  input wire logic [31:0] dat_in,
  output logic [31:0] dat_out,
  output logic ack_out,
  // to core
  output logic go_out,
  output logic abrst_out,
  output fwsr_mode_t mode_out,
  output logic [23:0] addr_out,
  output logic [15:0] expect_out,
  // from core
  input wire logic [5:0] stat_in,
  input wire logic [15:0] last_in
);
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic go_q, go_d, ab_q, ab_d;
  fwsr_mode_t mode_q, mode_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] exp_q, exp_d;
  logic hit;

  ////////////////////////////////////////////////////////////////////
  // decode, writes with byte enables, read mux
  always_comb begin
    hit = cyc_in && stb_in && !ack_q;
    ack_d = hit;
    dat_d = dat_q;
    go_d = 1'b0; // go and abort-reset are one-cycle pulses
    ab_d = 1'b0;
    mode_d = mode_q;
    addr_d = addr_q;
    exp_d = exp_q;
    if (hit && we_in) begin
      unique case (adr_in)
        REG_CTRL: begin
          if (sel_in[0]) begin
            go_d = dat_in[CTRL_GO];
            ab_d = dat_in[CTRL_ABRST];
            mode_d = fwsr_mode_t'(dat_in[CTRL_MODE]);
          end
        end
        REG_ADDR: begin
          if (sel_in[0]) addr_d[7:0] = dat_in[7:0];
          if (sel_in[1]) addr_d[15:8] = dat_in[15:8];
          if (sel_in[2]) addr_d[23:16] = dat_in[23:16];
        end
        REG_DATA: begin
          if (sel_in[0]) exp_d[7:0] = dat_in[7:0];
          if (sel_in[1]) exp_d[15:8] = dat_in[15:8];
        end
        default: ; // unmapped or read-only: write ignored
      endcase
    end
    if (hit && !we_in) begin
      unique case (adr_in)
        REG_CTRL: dat_d = {30'h0, 1'(mode_q), 1'b0};
        REG_ADDR: dat_d = {8'h00, addr_q};
        REG_STAT: dat_d = {26'h0, stat_in};
        REG_DATA: dat_d = {last_in, exp_q};
        default: dat_d = UNMAPPED_VAL;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
      go_q <= 1'b0;
      ab_q <= 1'b0;
      mode_q <= FWSR_TOGGLE;
      addr_q <= 24'h000000;
      exp_q <= 16'h0000;
    end else if (ce_in) begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      go_q <= go_d;
      ab_q <= ab_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      exp_q <= exp_d;
    end
  end

  assign ack_out = ack_q;
  assign dat_out = dat_q;
  assign go_out = go_q;
  assign abrst_out = ab_q;
  assign mode_out = mode_q;
  assign addr_out = addr_q;
  assign expect_out = exp_q;
endmodule : fwsr_wb_regs

// *** core/fwsr_top.sv ***
/*
  host-side write-status poller for a banked nor flash: software starts a
  poll of a program or erase, the block reads status words until done, aborted or
  failed, issues the reset command on failure and reports the result.
  assumes flash data in is synchronous to CLK_SYS_IN; the program or erase
  command itself was already written by software through other means.
*/
// Functional notes
// (R1) poll bit valid after final write strobe
// (R2) program: poll bit inverted until done
// (R3) protected program: poll active briefly, then array
// (R4) erase: poll bit 0, then 1
// (R5) all protected erase: poll briefly, then read
// (R6) bit7 may settle first; confirm with next read
// (R7) toggle bit flips each read while busy
// (R8) toggle bit valid through erase window
// (R9) protected erase toggles briefly then stops
// (R10) protected program toggles briefly then stops
// (R11) toggles during erase-suspend program too
// (R12) toggle advances only between distinct reads
// (R13) sector toggle bit toggles in erasing sectors
// (R14) two reads; unchanged toggle means done
// (R15) toggling plus limit flag: recheck, then reset
// (R16) limit flag high means operation failed
// (R17) 0-to-1 program may fail via limit flag
// (R18) after failure host writes reset command
// (R19) window flag 0 until erasure begins
// (R20) each sector erase restarts window
// (R21) host should watch window flag when queuing
// (R22) window flag 1: further commands ignored
// (R23) buffer abort flag needs abort reset
// (R24) busy bank returns status instead of data
`timescale 1ns/1ps
module fwsr_top
  import fwsr_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // flash pins
  output logic FL_CE_N_OUT,
  output logic FL_OE_N_OUT,
  output logic FL_WE_N_OUT,
  output logic [23:0] FL_ADDR_OUT,
  output logic [15:0] FL_DQ_OUT,
  output logic FL_DQ_OE_OUT,
  input wire logic [15:0] FL_DQ_IN
);
  // poll sequencer states
  typedef enum logic [3:0] {
    PS_IDLE, PS_READ1, PS_READ2, PS_CHECK, PS_RECHK, PS_CONFIRM,
    PS_RST1, PS_RST2, PS_RST3, PS_FINISH
  } fwsr_ps_t;

  fwsr_ps_t st_q, st_d;
  logic [15:0] prev_q, prev_d; // previous status word
  logic [15:0] last_q, last_d; // latest word read
  logic busy_q, busy_d, done_q, done_d, fail_q, fail_d, abt_q, abt_d;
  logic ewin_q, ewin_d, sect_q, sect_d;
  logic abr_q, abr_d; // reset is the buffer-abort reset
  logic cyc_go_q, cyc_go_d;
  fwsr_req_t req_q, req_d;
  logic go, abrst, cyc_done;
  fwsr_mode_t mode;
  logic [23:0] paddr;
  logic [15:0] expect_w, rdata;
  fwsr_pins_t pins;
  logic toggling, sect_tog, pbit_ok;

  ////////////////////////////////////////////////////////////////////
  // register slave
  fwsr_wb_regs u_regs (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .cyc_in(WB_CYC_IN),
    .stb_in(WB_STB_IN),
    .we_in(WB_WE_IN),
    .adr_in(WB_ADR_IN),
    .sel_in(WB_SEL_IN),
    .dat_in(WB_DAT_IN),
    .dat_out(WB_DAT_OUT),
    .ack_out(WB_ACK_OUT),
    .go_out(go),
    .abrst_out(abrst),
    .mode_out(mode),
    .addr_out(paddr),
    .expect_out(expect_w),
    .stat_in({sect_q, ewin_q, abt_q, fail_q, done_q, busy_q}),
    .last_in(last_q)
  );

  // one flash bus cycle engine
  fwsr_cycle u_cyc (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .start_in(cyc_go_q),
    .req_in(req_q),
    .done_out(cyc_done),
    .rdata_out(rdata),
    .pins_out(pins),
    .dq_in(FL_DQ_IN)
  );

  // pins leave straight from the cycle engine's flops
  assign FL_CE_N_OUT = pins.ce_n;
  assign FL_OE_N_OUT = pins.oe_n;
  assign FL_WE_N_OUT = pins.we_n;
  assign FL_ADDR_OUT = pins.addr;
  assign FL_DQ_OUT = pins.dq;
  assign FL_DQ_OE_OUT = pins.dq_oe;

  ////////////////////////////////////////////////////////////////////
  // comparisons between the two latest reads
  always_comb begin
    toggling = (rdata[PTOG_BIT] != prev_q[PTOG_BIT]); // R7 R12
    sect_tog = (rdata[STOG_BIT] != prev_q[STOG_BIT]); // R13
    // bit7 equals target once a program is done; erase target is 1
    pbit_ok = (rdata[POLL_BIT] == expect_w[POLL_BIT]); // R2 R4
  end

  ////////////////////////////////////////////////////////////////////
  // poll sequencer next state
  always_comb begin
    st_d = st_q;
    prev_d = prev_q;
    last_d = last_q;
    busy_d = busy_q;
    done_d = done_q;
    fail_d = fail_q;
    abt_d = abt_q;
    ewin_d = ewin_q;
    sect_d = sect_q;
    abr_d = abr_q;
    cyc_go_d = 1'b0;
    req_d = req_q;
    unique case (st_q)
      PS_IDLE: begin
        if (go) begin
          // first status read starts only after the final write strobe
          busy_d = 1'b1; // R1 R8
          done_d = 1'b0;
          fail_d = 1'b0;
          abt_d = 1'b0;
          req_d = '{wr: 1'b0, addr: paddr, wdata: 16'h0000};
          cyc_go_d = 1'b1;
          st_d = PS_READ1;
        end else if (abrst) begin
          // software-ordered buffer-abort reset
          busy_d = 1'b1;
          abr_d = 1'b1;
          req_d = '{wr: 1'b1, addr: ADDR_UNLOCK1, wdata: CMD_UNLOCK1};
          cyc_go_d = 1'b1;
          st_d = PS_RST1; // R23
        end
      end
      PS_READ1: begin
        if (cyc_done) begin
          prev_d = rdata;
          last_d = rdata;
          cyc_go_d = 1'b1; // second read of the pair
          st_d = PS_READ2; // R14
        end
      end
      PS_READ2, PS_RECHK: begin
        if (cyc_done) begin
          last_d = rdata;
          prev_d = rdata;
          ewin_d = rdata[EWIN_BIT]; // R19 R20 R21 R22
          sect_d = sect_tog;
          st_d = PS_CHECK;
          if (rdata[BABT_BIT] && !pbit_ok && mode == FWSR_DATA) begin
            // buffer abort stays until the abort reset; the bank keeps toggling
            // while aborted, so the flag counts only under data polling with a failed bit7 compare
            abt_d = 1'b1; // R23
            st_d = PS_FINISH;
          end else if (mode == FWSR_TOGGLE ? !toggling : pbit_ok) begin
            if (st_q == PS_RECHK && mode == FWSR_TOGGLE) begin
              // toggle stopped after the limit flag rose: failure
              fail_d = 1'b1; // R15
              abr_d = 1'b0;
              req_d = '{wr: 1'b1, addr: paddr, wdata: CMD_RESET};
              cyc_go_d = 1'b1;
              st_d = PS_RST3; // R18
            end else begin
              // status gone: one more read gives the true full word
              cyc_go_d = 1'b1; // R6 R3 R5 R9 R10 R24
              st_d = PS_CONFIRM;
            end
          end else if (rdata[TLIM_BIT]) begin
            // limit flag high while still busy: recheck while toggling, or confirm once in data mode
            cyc_go_d = 1'b1; // R15 R16 R17
            st_d = (mode == FWSR_TOGGLE) ? PS_RECHK : PS_CONFIRM;
          end else begin
            // still busy, including erase-suspend programming
            cyc_go_d = 1'b1; // R11
            st_d = PS_READ2;
          end
        end
      end
      PS_CONFIRM: begin
        if (cyc_done) begin
          last_d = rdata;
          if (mode == FWSR_DATA && !pbit_ok) begin
            // bit7 still not true data: timing limit reached
            fail_d = 1'b1; // R16
            abr_d = 1'b0;
            req_d = '{wr: 1'b1, addr: paddr, wdata: CMD_RESET};
            cyc_go_d = 1'b1;
            st_d = PS_RST3; // R18
          end else begin
            done_d = 1'b1; // R6
            st_d = PS_FINISH;
          end
        end
      end
      PS_RST1: begin
        if (cyc_done) begin
          req_d = '{wr: 1'b1, addr: ADDR_UNLOCK2, wdata: CMD_UNLOCK2};
          cyc_go_d = 1'b1;
          st_d = PS_RST2;
        end
      end
      PS_RST2: begin
        if (cyc_done) begin
          req_d = '{wr: 1'b1, addr: ADDR_UNLOCK1, wdata: CMD_RESET};
          cyc_go_d = 1'b1;
          st_d = PS_RST3;
        end
      end
      PS_RST3: begin
        if (cyc_done) begin
          if (abr_q) abt_d = 1'b0;
          st_d = PS_FINISH;
        end
      end
      PS_FINISH: begin
        busy_d = 1'b0;
        st_d = PS_IDLE;
      end
      default: st_d = PS_IDLE;
    endcase
  end

  // poll sequencer registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      st_q <= PS_IDLE;
      prev_q <= 16'h0000;
      last_q <= 16'h0000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      abt_q <= 1'b0;
      ewin_q <= 1'b0;
      sect_q <= 1'b0;
      abr_q <= 1'b0;
      cyc_go_q <= 1'b0;
      req_q <= '0;
    end else if (CE_IN) begin
      st_q <= st_d;
      prev_q <= prev_d;
      last_q <= last_d;
      busy_q <= busy_d;
      done_q <= done_d;
      fail_q <= fail_d;
      abt_q <= abt_d;
      ewin_q <= ewin_d;
      sect_q <= sect_d;
      abr_q <= abr_d;
      cyc_go_q <= cyc_go_d;
      req_q <= req_d;
    end
  end
endmodule : fwsr_top

// *** verif/fwsr_top_asserts.sv ***
/*
  checker for the poller top: wishbone answer timing and flash strobes.
  assumes it is bound to fwsr_top and sees only its ports.
*/
`timescale 1ns/1ps
module fwsr_top_asserts (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // wishbone
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_ACK_OUT,
  // flash pins
  input wire logic FL_CE_N_OUT,
  input wire logic FL_OE_N_OUT,
  input wire logic FL_WE_N_OUT,
  input wire logic [23:0] FL_ADDR_OUT,
  input wire logic FL_DQ_OE_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////
  // a read is three active cycles, then two idle ones
  sequence rd_act_s;
    (!FL_OE_N_OUT && !FL_CE_N_OUT) [*3];
  endsequence
  sequence rd_gap_s;
    FL_OE_N_OUT [*2];
  endsequence
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (CE_IN && WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("ack missing one cycle after request");
  ack_cause_a: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN) && $past(WB_STB_IN))
    else $error("ack without request");
  strobe_len_a: assert property ($fell(FL_OE_N_OUT) |-> rd_act_s ##1 rd_gap_s)
    else $error("read strobe length or gap wrong");
  chip_release_a: assert property ($rose(FL_OE_N_OUT) |-> FL_CE_N_OUT)
    else $error("chip select kept low between reads");
  addr_hold_a: assert property (!FL_OE_N_OUT && !$past(FL_OE_N_OUT) |->
    $stable(FL_ADDR_OUT))
    else $error("address moved during read");
  dq_release_a: assert property (!FL_OE_N_OUT |-> !FL_DQ_OE_OUT)
    else $error("host drives data during read");
  wr_excl_a: assert property (!FL_WE_N_OUT |-> FL_OE_N_OUT && FL_DQ_OE_OUT)
    else $error("write strobe without data drive");
endmodule : fwsr_top_asserts

bind fwsr_top fwsr_top_asserts u_fwsr_top_asserts (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_ACK_OUT(WB_ACK_OUT),
  .FL_CE_N_OUT(FL_CE_N_OUT), .FL_OE_N_OUT(FL_OE_N_OUT), .FL_WE_N_OUT(FL_WE_N_OUT),
  .FL_ADDR_OUT(FL_ADDR_OUT), .FL_DQ_OE_OUT(FL_DQ_OE_OUT));

// *** verif/fwsr_flash_model.sv ***
/*
  behavioural flash bank: status word while busy, array word after.
  assumes strobes are synchronous to clk_in; bench arms each operation.
*/
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  // clock and bench control
  input wire logic clk_in,
  input wire logic arm_in,
  input wire logic fail_in,
  input wire logic [7:0] busy_in,
  input wire logic [15:0] arr_in,
  input wire logic erase_in,
  input wire logic abort_in,
  // flash pins
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  // observations
  output logic rst_out,
  output logic [1:0] unl_out
);
  logic oe_q, we_q, tog_q, busy; // previous strobes, toggle, busy
  logic [7:0] cnt_q; // reads answered while busy
  logic [15:0] last_q, cap_d, word; // last driven, captured write
  logic [23:0] cap_a;
  ////////////////////////////////////////////////////////////////////////
  // a failed operation stays busy until the reset command
  // an aborted buffer load stays busy until the abort reset sequence
  assign busy = abort_in ? (unl_out != 2'h3) :
                fail_in ? !rst_out : (cnt_q < busy_in);
  // erase shows the window flag and a sector toggle, abort its own flag
  assign word = busy ? {8'h00, ~arr_in[7], tog_q, fail_in, 1'b0, erase_in, erase_in & tog_q,
                        abort_in, 1'b0} : arr_in;
  // released bus shows the inverse, never a stale match
  assign dq_out = (ce_n_in || oe_n_in) ? ~last_q : word;
  // read counting and command capture
  always_ff @(posedge clk_in) begin
    oe_q <= oe_n_in;
    we_q <= we_n_in;
    if (!oe_n_in && !ce_n_in) last_q <= word;
    if (!we_n_in) begin
      cap_a <= addr_in;
      cap_d <= dq_in;
    end
    if (arm_in) begin
      cnt_q <= 8'h00;
      tog_q <= 1'b0;
      rst_out <= 1'b0;
      unl_out <= 2'h0;
    end else begin
      // only a new read advances the toggle
      if (oe_q && !oe_n_in && !ce_n_in && busy && cnt_q < busy_in) begin
        cnt_q <= cnt_q + 8'h01;
        tog_q <= ~tog_q;
      end
      if (!we_q && we_n_in) begin
        if (cap_a == ADDR_UNLOCK1 && cap_d == CMD_UNLOCK1) unl_out <= 2'h1;
        else if (unl_out == 2'h1 && cap_a == ADDR_UNLOCK2 && cap_d == CMD_UNLOCK2)
          unl_out <= 2'h2;
        else if (unl_out == 2'h2 && cap_a == ADDR_UNLOCK1 && cap_d == CMD_RESET)
          unl_out <= 2'h3;
        else if (cap_d == CMD_RESET) rst_out <= 1'b1;
      end
    end
  end
endmodule : fwsr_flash_model

// *** verif/tb_top.sv ***
/*
  bench for the poller: wishbone tasks drive polls against the model.
  assumes the flash model ignores the address on reads and answers the same everywhere.
*/
`timescale 1ns/1ps
module tb_top;
  import fwsr_pkg::*;
  logic clk, rst, cyc, stb, we, ack, ce_n, oe_n, we_n, dq_oe;
  logic arm, fail, rst_seen, ce, erase, abrt;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, v;
  logic [23:0] faddr;
  logic [15:0] fdo, fdi, arr;
  logic [7:0] busy;
  logic [1:0] unl;
  int mismatches, num_checks;
  ////////////////////////////////////////////////////////////////////////
  fwsr_top u_fwsr_top (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n), .FL_WE_N_OUT(we_n),
    .FL_ADDR_OUT(faddr), .FL_DQ_OUT(fdo), .FL_DQ_OE_OUT(dq_oe), .FL_DQ_IN(fdi));
  fwsr_flash_model u_fwsr_flash_model (.clk_in(clk), .arm_in(arm), .fail_in(fail),
    .busy_in(busy), .arr_in(arr), .erase_in(erase), .abort_in(abrt), .ce_n_in(ce_n),
    .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(faddr), .dq_in(fdo), .dq_out(fdi), .rst_out(rst_seen), .unl_out(unl));
  // clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle: hold until ack, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 50) begin
      mismatches++;
      end_sim();
    end
  endtask : wb
  // arm model, start a poll and wait until idle
  task automatic poll(input logic f, input logic [7:0] b, input logic [15:0] a,
                      input logic m);
    int n;
    @(posedge clk);
    arm <= 1'b1;
    fail <= f;
    busy <= b;
    arr <= a;
    @(posedge clk);
    arm <= 1'b0;
    wb(1'b1, REG_ADDR, 32'h00000100);
    wb(1'b1, REG_DATA, {16'h0000, a});
    wb(1'b1, REG_CTRL, {30'h0, m, 1'b1});
    for (n = 0; n < 300; n++) begin
      wb(1'b0, REG_STAT, 32'h0);
      if (v[ST_BUSY] === 1'b0 && (v[ST_DONE] | v[ST_FAIL] | v[ST_ABORT]) === 1'b1) break;
    end
    if (n == 300) begin
      mismatches++;
      end_sim();
    end
  endtask : poll
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, arm, fail, erase, abrt} = 7'h00;
    ce = 1'b1;
    adr = 4'h0;
    wdat = 32'h0;
    busy = 8'h00;
    arr = 16'h0000;
    mismatches = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // idle state and unmapped place
    wb(1'b0, REG_STAT, 32'h0);
    check(v, 32'h0);
    wb(1'b1, 4'h1, 32'hffffffff);
    wb(1'b0, 4'h1, 32'h0);
    check(v, UNMAPPED_VAL);
    // toggle polling ends on array data, no reset command
    poll(1'b0, 8'h05, 16'h1234, 1'b0);
    check(v[ST_FAIL], 1'b0);
    wb(1'b0, REG_DATA, 32'h0);
    check(v[31:16], 16'h1234);
    check(rst_seen, 1'b0);
    // data polling on bit7 with a programmed word 00a5
    poll(1'b0, 8'h07, 16'h00a5, 1'b1);
    check(v[ST_DONE], 1'b1);
    wb(1'b0, REG_DATA, 32'h0);
    check(v[31:16], 16'h00a5);
    // toggling with limit flag, then frozen: fail and reset
    poll(1'b1, 8'h04, 16'h5a5a, 1'b0);
    check(v[ST_FAIL], 1'b1);
    check(rst_seen, 1'b1);
    // erase hits its limit under data polling: window and sector bits kept
    erase <= 1'b1;
    poll(1'b1, 8'h04, 16'hffff, 1'b1);
    check(v[ST_FAIL], 1'b1);
    check(v[ST_EWIN], 1'b1);
    check(v[ST_SECT], 1'b1);
    check(rst_seen, 1'b1);
    // buffered program aborts: flag stands until the abort reset
    erase <= 1'b0;
    abrt <= 1'b1;
    poll(1'b0, 8'h10, 16'h00a5, 1'b1);
    check(v[ST_ABORT], 1'b1);
    check(v[ST_DONE], 1'b0);
    wb(1'b1, REG_CTRL, 32'h00000004);
    // freeze in the first write strobe: nothing may advance meanwhile
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    check(we_n, 1'b0);
    check(unl, 2'h0);
    ce <= 1'b1;
    repeat (100) @(posedge clk);
    check(unl, 2'h3);
    wb(1'b0, REG_STAT, 32'h0);
    check(v[ST_ABORT], 1'b0);
    end_sim();
  end
endmodule : tb_top
